// File: logic/scg_pkg.sv
// Constants, types and lookups for the clock gating and strap select block.
// Assumes one 125 MHz system clock and a classic Wishbone register port.
// Overview of operation
// - Mode strap latched at power-on: 1 desktop
// - Mode 0: stop inputs; mode 1: memory clocks
// - Frequency straps sampled once, later changes ignored
// - CPU stop gates processor clocks low, delayed restart
// - PCI stop gates five peripheral clocks low
// - Free peripheral clock stops only in power-down
// - Memory stop holds all memory clocks low
// - Power-down overrides stops, halts every clock
// - Super I/O strap picks 14.318 or 24 MHz
// - Voltage strap picks 3.3 V or 2.5 V drivers
// - Follow bit plus frequency bits decode frequencies
// - Reference and interrupt clocks stay fixed
// - Fixed 48 MHz output ignores frequency select
// - Strap pins input only during power-on reset
// - Gated clocks stop low, restart full pulses
// - Processor clock on/off within four cycles
package scg_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_FREQ0 = 8'h08;
   localparam logic [7:0] OFS_FREQ1 = 8'h0c;
   // Control register fields and reset value
   localparam int CTRL_SWSEL_BIT = 0;
   localparam int CTRL_CODE_LSB = 1;
   localparam int CTRL_SPREAD_BIT = 5;
   localparam logic [5:0] CTRL_RST = 6'h00;
   // Strap pin positions
   localparam int SP_MODE = 0;
   localparam int SP_FREQ_B0 = 1;
   localparam int SP_FREQ_B1 = 2;
   localparam int SP_FREQ_B2 = 3;
   localparam int SP_SUPERIO = 4;
   localparam int SP_VOLT = 5;
   localparam int SP_FOLLOW = 6;
   // Shared pin positions
   localparam int SH_CPU_STOP = 0;
   localparam int SH_PCI_STOP = 1;
   localparam int SH_MEM_STOP = 2;
   localparam int SH_PD = 3;
   // Filter reset: stops idle high, straps low
   localparam logic [10:0] FLT_RST = 11'h00f;
   // Timing
   localparam int CLK_MHZ = 125;
   localparam int STRAP_NS = 64;
   localparam int STRAP_CYC = (STRAP_NS * CLK_MHZ + 999) / 1000;
   localparam int CPU_ON_WAIT = 2;
   localparam int PD_MAX_MS = 3;
   localparam int PD_MAX_CYC = PD_MAX_MS * CLK_MHZ * 1000;
   localparam int SYNC_LAT = 4;
   // Latched strap set
   typedef struct packed {
      logic mode;
      logic follow;
      logic superio;
      logic volt;
      logic [2:0] fs;
   } scg_strap_t;
   // Operating phase
   typedef enum logic [1:0] {
      ST_STRAP = 2'b00,
      ST_RUN = 2'b01,
      ST_DOWN = 2'b10
   } scg_phase_t;
   // Frequency table {cpu, mem, pci}, units of 10 kHz
   function automatic logic [47:0] freq_decode(input logic [3:0] code);
      logic [47:0] f;
      f = 48'h0;
      unique case (code)
         4'h0: f = {16'h2328, 16'h2328, 16'h0bb8};
         4'h1: f = {16'h1a0e, 16'h2715, 16'h0d07};
         4'h2: f = {16'h251c, 16'h18bd, 16'h0c5e};
         4'h3: f = {16'h2710, 16'h1a0a, 16'h0d05};
         4'h4: f = {16'h2710, 16'h1d4c, 16'h0bb8};
         4'h5: f = {16'h2bc0, 16'h1d2a, 16'h0e95};
         4'h6: f = {16'h3070, 16'h204a, 16'h0c1c};
         4'h7: f = {16'h3412, 16'h22b6, 16'h0d04};
         4'h8: f = {16'h1a0e, 16'h1a0e, 16'h0d07};
         4'h9: f = {16'h1d4c, 16'h1d4c, 16'h0bb8};
         4'ha: f = {16'h208a, 16'h208a, 16'h0d04};
         4'hb: f = {16'h251c, 16'h251c, 16'h0c5e};
         4'hc: f = {16'h2710, 16'h2710, 16'h0d05};
         4'hd: f = {16'h2bc0, 16'h2bc0, 16'h0e95};
         4'he: f = {16'h3070, 16'h3070, 16'h0c1c};
         4'hf: f = {16'h3412, 16'h3412, 16'h0d05};
      endcase
      return f;
   endfunction
endpackage

// File: logic/scg_top.sv
// Clock gating, strap capture and register port of the clock synthesizer.
// Assumes straps are stable around reset release and stop pins are async.
`timescale 1ns/1ps
module scg_top #(
   parameter int PD_ENTRY_CYC = scg_pkg::PD_MAX_CYC
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [3:0] wb_sel_in,
   input wire logic [31:0] wb_dat_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic [6:0] strap_pin_in,
   output logic [6:0] strap_pin_out,
   output logic [6:0] strap_pin_oe_out,
   input wire logic [3:0] shared_pin_in,
   output logic [3:0] shared_pin_out,
   output logic [3:0] shared_pin_oe_out,
   output logic [2:0] processor_clk_out,
   output logic [3:0] gated_periph_clk_out,
   output logic [8:0] mem_clk_out,
   output logic irq_controller_clk_out,
   output logic proc_buffer_2v5_out,
   output logic spread_enable_out,
   output logic osc_run_out
);
   import scg_pkg::*;

   // Clock stand-ins: one 4-bit phase counter runs in the run phase.
   // Bit 0 stands for the processor clock, bit 1 for the peripheral
   // clocks, bit 2 for the fixed 48 MHz and fast super I/O clocks,
   // bit 3 for the reference and interrupt-controller clocks.
   // Each output is a flop fed with the next counter value, so all
   // stand-ins of one group change on the same edge.
   // Gating never touches the counter itself: a stopped group only
   // masks its output, so the other groups keep their phase.
   // Power-down forces the counter to zero, which parks every
   // stand-in low and restarts them from a known phase.
   // Limitation: real rates and spread modulation are not modelled;
   // software reads the decoded rates from the frequency registers.
   // Memory clocks follow the processor stand-in when the follow
   // strap is set, otherwise the peripheral stand-in.

   // Power-down entry must fit the synchroniser latency
   if (PD_ENTRY_CYC < SYNC_LAT + 1) begin : g_chk
      $error("PD_ENTRY_CYC too small for synchroniser latency");
   end

   // State layout notes:
   // phase - strap capture, run or power-down
   // cnt - clock stand-in counter
   // strap_cnt - cycles spent in the strap window
   // s1, s2, s3 - three-flop pin synchroniser, straps above stops
   // flt - filtered pin levels, moved when s2 and s3 agree
   // strap - latched strap set, held until the next reset
   // ctrl - software control register
   // cpu_wait - restart delay after a processor stop release
   // Gate bits - group enables, moved only in a low phase
   // ack, dat - registered bus answer
   // Output fields - registered clock and pin outputs
   // Whole block state
   typedef struct packed {
      scg_phase_t phase;
      logic [3:0] cnt;
      logic [3:0] strap_cnt;
      logic [10:0] s1;
      logic [10:0] s2;
      logic [10:0] s3;
      logic [10:0] flt;
      scg_strap_t strap;
      logic [5:0] ctrl;
      logic [1:0] cpu_wait;
      logic cpu_gate;
      logic pci_gate;
      logic mem_gate;
      logic ack;
      logic [31:0] dat;
      logic [6:0] strap_o;
      logic [3:0] shared_o;
      logic [2:0] cpu_o;
      logic [3:0] pci_o;
      logic [8:0] mem_o;
      logic irq_o;
   } scg_state_t;

   scg_state_t st_r;
   scg_state_t st_nxt;

   // Filter hazard: the first stage may go metastable, so only the
   // second and third stages are compared. A level that differs
   // between them is not yet trusted and the old value is kept.
   // A glitch shorter than one cycle can therefore never reach
   // the gates or the strap latch.
   // Counts a change once second and third stages agree
   function automatic logic [10:0] filt(input logic [10:0] a,
                                        input logic [10:0] b,
                                        input logic [10:0] old);
      return (~(a ^ b) & b) | ((a ^ b) & old);
   endfunction

   // Gate hazard: moving a gate while its source is high would cut
   // a high phase short. Holding the gate until the source is low
   // makes every stop land low and every restart begin with a
   // complete high phase.
   // The source passed in is the current counter bit, so the
   // output flop launched with the new gate starts a fresh phase.
   // Gate moves only while its source is low, so highs stay whole
   function automatic logic gate_upd(input logic src, input logic want,
                                     input logic old);
      return src ? old : want;
   endfunction

   // Combinational helpers
   logic [3:0] stops_n;
   logic [3:0] code;
   logic [47:0] freq;
   logic cpu_want;
   logic run;
   logic s_cpu, s_pci, s_mem, s_ref, s_48, s_superio;
   logic [3:0] cn;
   logic bus_req;

   // Next state
   always_comb begin
      st_nxt = st_r;
      // Pin synchronisers, three stages
      st_nxt.s1 = {strap_pin_in, shared_pin_in};
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.flt = filt(st_r.s2, st_r.s3, st_r.flt);
      // Desktop mode has no stop pins: all read inactive
      stops_n = st_r.strap.mode ? 4'hf : st_r.flt[3:0];
      run = 1'b0;
      unique case (st_r.phase)
         // Strap window: the pins are inputs and the filter settles.
         // The window outlasts the filter delay, so the latched set
         // reflects the board straps, not the reset value of the
         // filter. After the latch the set never changes until reset.
         ST_STRAP: begin
            // Straps read as inputs until the window ends
            st_nxt.strap_cnt = st_r.strap_cnt + 4'h1;
            if (st_r.strap_cnt == 4'(STRAP_CYC)) begin
               st_nxt.strap.mode = st_r.flt[4 + SP_MODE];
               st_nxt.strap.fs = {st_r.flt[4 + SP_FREQ_B2],
                                  st_r.flt[4 + SP_FREQ_B1],
                                  st_r.flt[4 + SP_FREQ_B0]};
               st_nxt.strap.superio = st_r.flt[4 + SP_SUPERIO];
               st_nxt.strap.volt = st_r.flt[4 + SP_VOLT];
               st_nxt.strap.follow = st_r.flt[4 + SP_FOLLOW];
               st_nxt.phase = ST_RUN;
            end
         end
         ST_RUN: begin
            run = 1'b1;
            if (!stops_n[SH_PD]) begin
               st_nxt.phase = ST_DOWN;
            end
         end
         ST_DOWN: begin
            if (stops_n[SH_PD]) begin
               st_nxt.phase = ST_RUN;
            end
         end
         default: begin
            st_nxt.phase = ST_STRAP;
         end
      endcase
      // Oscillator halts in power-down; restart from zero phase
      cn = run ? st_r.cnt + 4'h1 : 4'h0;
      st_nxt.cnt = cn;
      // Source clocks of next cycle
      s_cpu = cn[0];
      s_pci = cn[1];
      s_mem = st_r.strap.follow ? cn[0] : cn[1];
      s_ref = cn[3];
      s_48 = cn[2];
      s_superio = st_r.strap.superio ? cn[2] : cn[3];
      // Processor restart: the released stop must first pass the
      // filter, then the wait counter, then a low phase of the
      // processor stand-in. That keeps the turn-on latency above
      // three processor periods and below four.
      // Stopping needs no wait: the want bit drops as soon as the
      // filtered level goes low, and the gate follows in the next
      // low phase, well inside four processor periods.
      // The wait counter saturates, so a long run costs nothing.
      // Processor restart waits after release
      if (!stops_n[SH_CPU_STOP]) begin
         st_nxt.cpu_wait = 2'h0;
      end else if (st_r.cpu_wait != 2'(CPU_ON_WAIT)) begin
         st_nxt.cpu_wait = st_r.cpu_wait + 2'h1;
      end
      cpu_want = stops_n[SH_CPU_STOP] &&
                 st_r.cpu_wait == 2'(CPU_ON_WAIT);
      // Group gates, moved only in a low phase
      st_nxt.cpu_gate = gate_upd(st_r.cnt[0], cpu_want,
                                 st_r.cpu_gate);
      st_nxt.pci_gate = gate_upd(st_r.cnt[1], stops_n[SH_PCI_STOP],
                                 st_r.pci_gate);
      st_nxt.mem_gate = gate_upd(st_r.strap.follow ? st_r.cnt[0]
                                 : st_r.cnt[1], stops_n[SH_MEM_STOP],
                                 st_r.mem_gate);
      // Output flops
      st_nxt.cpu_o = {3{s_cpu & st_nxt.cpu_gate}};
      st_nxt.pci_o = {4{s_pci & st_nxt.pci_gate}};
      st_nxt.mem_o = {9{s_mem & st_nxt.mem_gate}};
      st_nxt.irq_o = s_ref;
      // Strap pins from bit 0: reference 0, 48 MHz, free peripheral,
      // gated peripheral 0, super I/O, reference 2, reference 1
      st_nxt.strap_o = {s_ref, s_ref, s_superio, s_pci & st_nxt.pci_gate,
                        s_pci, s_48, s_ref};
      // Desktop mode drives memory clocks 12..9 on shared pins
      st_nxt.shared_o = st_r.strap.mode ?
                        {4{s_mem & st_nxt.mem_gate}} : 4'h0;
      // Bus answer: ack rises one cycle after a request is seen and
      // falls the cycle after, so a held request is answered every second cycle.
      // Read data is built in the request cycle and stands only
      // while ack is high; it is zero otherwise.
      // Unmapped offsets read zero and ignore writes.
      // Only the low byte lane of the control register is writable.
      // Wishbone slave, one wait state
      bus_req = wb_cyc_in & wb_stb_in;
      st_nxt.ack = bus_req & ~st_r.ack;
      code = st_r.ctrl[CTRL_SWSEL_BIT] ?
             {st_r.strap.follow, st_r.ctrl[CTRL_CODE_LSB +: 3]} :
             {st_r.strap.follow, st_r.strap.fs};
      freq = freq_decode(code);
      st_nxt.dat = 32'h0;
      if (bus_req & ~st_r.ack & ~wb_we_in) begin
         unique case (wb_adr_in)
            OFS_CTRL: st_nxt.dat = {26'h0, st_r.ctrl};
            // Status: stops 12:9, mode, follow, super I/O, voltage,
            // frequency straps 4:2, phase 1:0
            OFS_STATUS: st_nxt.dat = {19'h0, stops_n, st_r.strap.mode,
                                      st_r.strap.follow, st_r.strap.superio,
                                      st_r.strap.volt, st_r.strap.fs,
                                      st_r.phase};
            OFS_FREQ0: st_nxt.dat = freq[47:16];
            OFS_FREQ1: st_nxt.dat = {16'h0, freq[15:0]};
            default: st_nxt.dat = 32'h0;
         endcase
      end
      // Write lands on the edge the master sees ack
      if (bus_req & st_r.ack & wb_we_in & wb_sel_in[0] &&
          wb_adr_in == OFS_CTRL) begin
         st_nxt.ctrl = wb_dat_in[5:0];
      end
   end

   // Reset: synchronous and active low. Stop levels reset to their
   // idle high value and straps to zero, so no false stop is seen
   // while the synchroniser refills after release.
   // Gates reset closed; they open in the strap window, where the
   // counter is held at zero, so the first high pulse is whole.
   // State register
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         st_r.phase <= ST_STRAP;
         st_r.cnt <= 4'h0;
         st_r.strap_cnt <= 4'h0;
         st_r.s1 <= FLT_RST;
         st_r.s2 <= FLT_RST;
         st_r.s3 <= FLT_RST;
         st_r.flt <= FLT_RST;
         st_r.strap <= '0;
         st_r.ctrl <= CTRL_RST;
         st_r.cpu_wait <= 2'h0;
         st_r.cpu_gate <= 1'b0;
         st_r.pci_gate <= 1'b0;
         st_r.mem_gate <= 1'b0;
         st_r.ack <= 1'b0;
         st_r.dat <= 32'h0;
         st_r.strap_o <= 7'h00;
         st_r.shared_o <= 4'h0;
         st_r.cpu_o <= 3'h0;
         st_r.pci_o <= 4'h0;
         st_r.mem_o <= 9'h000;
         st_r.irq_o <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Pin enables stay low through the strap window so the board
   // straps can be read; afterwards the shared pins drive only in
   // desktop mode, when they carry memory clocks.
   // In mobile mode the shared pins stay inputs for the stop and
   // power-down requests of the power manager.
   // Outputs, all from flops
   assign wb_dat_out = st_r.dat;
   assign wb_ack_out = st_r.ack;
   assign strap_pin_out = st_r.strap_o;
   assign strap_pin_oe_out = {7{st_r.phase != ST_STRAP}};
   assign shared_pin_out = st_r.shared_o;
   assign shared_pin_oe_out = {4{st_r.strap.mode &&
                                 st_r.phase != ST_STRAP}};
   assign processor_clk_out = st_r.cpu_o;
   assign gated_periph_clk_out = st_r.pci_o;
   assign mem_clk_out = st_r.mem_o;
   assign irq_controller_clk_out = st_r.irq_o;
   assign proc_buffer_2v5_out = st_r.strap.volt;
   assign spread_enable_out = st_r.ctrl[CTRL_SPREAD_BIT];
   assign osc_run_out = st_r.phase == ST_RUN;
endmodule

// File: tb/scg_pmc_model.sv
// Power manager stand-in that drives the four active-low stop pins.
// Assumes the bench commands the levels; the pins move off the clock.
`timescale 1ns/1ps
module scg_pmc_model (
   input wire logic [3:0] stop_cmd_n_in, // Wanted pin levels
   input wire logic slow_in, // Pick the slow answer
   output logic [3:0] stop_pin_n_out // Asynchronous stop pins
);
   // Idle: no stop requested
   initial stop_pin_n_out = 4'hf;
   // Pins follow commands after a delay unrelated to the clock
   always @(stop_cmd_n_in) begin
      if (slow_in) begin
         stop_pin_n_out <= #37 stop_cmd_n_in;
      end else begin
         stop_pin_n_out <= #3 stop_cmd_n_in;
      end
   end
endmodule

// File: tb/scg_properties.sv
// Port-level checks of the clock gating and strap select block.
// Assumes one clock domain and the active-low synchronous reset.
`timescale 1ns/1ps
module scg_properties #(
   parameter int PD_ENTRY_CYC = 5
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_out,
   input wire logic wb_ack_out,
   input wire logic [6:0] strap_pin_out,
   input wire logic [6:0] strap_pin_oe_out,
   input wire logic [3:0] shared_pin_in,
   input wire logic [3:0] shared_pin_oe_out,
   input wire logic [2:0] processor_clk_out,
   input wire logic [3:0] gated_periph_clk_out,
   input wire logic [8:0] mem_clk_out,
   input wire logic irq_controller_clk_out,
   input wire logic osc_run_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   logic mob; // Mobile mode with power up
   assign mob = shared_pin_oe_out == 4'h0 && shared_pin_in[3];
   a_cpu_off: assert property ((mob && !shared_pin_in[0]) [*7]
      |-> processor_clk_out == 3'h0) else $error("cpu clocks not stopped");
   a_cpu_restart: assert property ($rose(shared_pin_in[0]) && mob
      && $past(processor_clk_out, 2) == 3'h0 && processor_clk_out == 3'h0
      |-> (processor_clk_out == 3'h0) [*5]) else $error("cpu restart early");
   a_pci_off: assert property ((mob && !shared_pin_in[1]) [*7]
      |-> gated_periph_clk_out == 4'h0 && !strap_pin_out[3])
      else $error("pci clocks not stopped");
   a_free_runs: assert property (mob && !shared_pin_in[1] && osc_run_out
      |-> ##[1:4] $changed(strap_pin_out[2])) else $error("free clock idle");
   a_mem_off: assert property ((mob && !shared_pin_in[2]) [*7]
      |-> mem_clk_out == 9'h0) else $error("memory clocks not stopped");
   a_pd_all_low: assert property ((shared_pin_oe_out == 4'h0
      && !shared_pin_in[3]) [*8] |-> {processor_clk_out, gated_periph_clk_out,
      mem_clk_out, irq_controller_clk_out, strap_pin_out, osc_run_out} == '0)
      else $error("power down left a clock running");
   a_mode_pins: assert property (shared_pin_oe_out != 4'h0
      |-> shared_pin_oe_out == 4'hf && strap_pin_oe_out == 7'h7f)
      else $error("shared pin enables wrong");
   a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
      |=> wb_ack_out) else $error("bus not answered");
   a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
      else $error("ack longer than one cycle");
   a_unmapped_zero: assert property (wb_ack_out && !wb_we_in
      && wb_adr_in > 8'h0c |-> wb_dat_out == 32'h0)
      else $error("unmapped read not zero");
   // Main scenarios reached
   c_cpu_stop: cover property (mob && !shared_pin_in[0]);
   c_pd: cover property (!shared_pin_in[3] && shared_pin_oe_out == 4'h0);
   c_desktop: cover property (shared_pin_oe_out == 4'hf);
endmodule
bind scg_top scg_properties #(.PD_ENTRY_CYC(PD_ENTRY_CYC)) u_props (
   .mclk_in(mclk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
   .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .strap_pin_out(strap_pin_out), .strap_pin_oe_out(strap_pin_oe_out),
   .shared_pin_in(shared_pin_in), .shared_pin_oe_out(shared_pin_oe_out),
   .processor_clk_out(processor_clk_out),
   .gated_periph_clk_out(gated_periph_clk_out), .mem_clk_out(mem_clk_out),
   .irq_controller_clk_out(irq_controller_clk_out), .osc_run_out(osc_run_out));

// File: tb/tb.sv
// Self-checking bench for the clock gating and strap select block.
// Assumes the power manager model drives the shared stop pins.
`timescale 1ns/1ps
module tb;
   logic mclk_in = 1'b0, nrst_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic slow = 1'b0; // Partner answer speed
   logic [7:0] adr = 8'h0;
   logic [3:0] sel = 4'h0, cmd_n = 4'hf; // Stop commands
   logic [31:0] dat = 32'h0, seen;
   logic [6:0] st = 7'h0; // Strap levels
   logic [5:0] tbl [4] = '{6'h1f, 6'h2f, 6'h37, 6'h00}; // Groups alive
   // Peripheral rate per {follow, frequency straps}, units of 10 kHz
   logic [15:0] pci_rate [16] = '{16'h0bb8, 16'h0d07, 16'h0c5e, 16'h0d05,
      16'h0bb8, 16'h0e95, 16'h0c1c, 16'h0d04, 16'h0d07, 16'h0bb8, 16'h0d04,
      16'h0c5e, 16'h0d05, 16'h0e95, 16'h0c1c, 16'h0d05};
   logic [31:0] expq [$]; // Expected read data
   int error_cnt = 0, total_checks = 0;
   wire [31:0] rd;
   wire [6:0] sp_out, sp_oe, sp_w;
   wire [3:0] sh_out, sh_oe, sh_w, pmc, gclk;
   wire [2:0] pclk;
   wire [8:0] mclk9;
   wire ack, irq, v25, spr, osc;
   // Pin levels from whichever side drives
   assign sp_w = (sp_oe & sp_out) | (~sp_oe & st);
   assign sh_w = (sh_oe & sh_out) | (~sh_oe & pmc);
   always #4 mclk_in = ~mclk_in;
   scg_pmc_model u_scg_pmc_model (.stop_cmd_n_in(cmd_n), .slow_in(slow),
      .stop_pin_n_out(pmc));
   scg_top #(.PD_ENTRY_CYC(5)) u_scg_top (.mclk_in(mclk_in),
      .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
      .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat), .wb_dat_out(rd),
      .wb_ack_out(ack), .strap_pin_in(sp_w), .strap_pin_out(sp_out),
      .strap_pin_oe_out(sp_oe), .shared_pin_in(sh_w), .shared_pin_out(sh_out),
      .shared_pin_oe_out(sh_oe), .processor_clk_out(pclk),
      .gated_periph_clk_out(gclk), .mem_clk_out(mclk9),
      .irq_controller_clk_out(irq), .proc_buffer_2v5_out(v25),
      .spread_enable_out(spr), .osc_run_out(osc));
   // Compare one value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic bus cycle, held until ack
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge mclk_in);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
      do begin
         @(posedge mclk_in);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) error_cnt++;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
   endtask
   // Rising edges of the fixed clocks over 32 cycles
   task automatic count_rises(output logic [31:0] r);
      logic [6:0] p;
      logic q;
      p = sp_out;
      q = irq;
      r = 32'h0;
      repeat (32) begin
         @(posedge mclk_in);
         r[31:24] += 8'(sp_out[0] & ~p[0]);
         r[23:16] += 8'(sp_out[1] & ~p[1]);
         r[15:8] += 8'(sp_out[4] & ~p[4]);
         r[7:0] += 8'(irq & ~q);
         p = sp_out;
         q = irq;
      end
   endtask
   task automatic close_out;
      $display("Checks %0d, errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Read data meets the oldest note
   always @(posedge mclk_in) begin
      if (ack === 1'b1 && we === 1'b0) begin
         chk(rd, expq.pop_front());
      end
   end
   // Hang guard
   initial begin
      #50us;
      error_cnt++;
      close_out;
   end
   initial begin
      void'($urandom(32'had8b));
      for (int m = 0; m < 2; m++) begin
         st <= {m[0], 5'($urandom), m[0]};
         nrst_in <= 1'b0;
         repeat (16) @(posedge mclk_in);
         nrst_in <= 1'b1;
         repeat (14) @(posedge mclk_in);
         expq.push_back({19'h0, 4'hf, st[0], st[6], st[4], st[5], st[3:1],
            2'b01});
         wb(8'h04, 1'b0, 32'h0);
         chk(v25, st[5]);
         chk(sp_oe, 7'h7f);
         chk(sh_oe, m ? 4'hf : 4'h0);
         expq.push_back({16'h0, pci_rate[{m[0], st[3:1]}]});
         wb(8'h0c, 1'b0, 32'h0);
         wb(8'h00, 1'b1, 32'h2f);
         expq.push_back(32'h2f);
         wb(8'h00, 1'b0, 32'h0);
         chk(spr, 1'b1);
         expq.push_back(m ? 32'h34123412 : 32'h341222b6);
         wb(8'h08, 1'b0, 32'h0);
         expq.push_back(m ? 32'h0d05 : 32'h0d04);
         wb(8'h0c, 1'b0, 32'h0);
         expq.push_back(32'h0);
         wb(8'h10, 1'b0, 32'h0);
         count_rises(seen);
         chk(seen, st[4] ? 32'h02040402 : 32'h02040202);
         for (int i = 0; i < 4 && m == 0; i++) begin
            slow <= i[0];
            cmd_n[i] <= 1'b0;
            repeat (12) @(posedge mclk_in);
            seen = 32'h0;
            repeat (16) begin
               @(posedge mclk_in);
               seen |= {|pclk, |gclk | sp_out[3], |mclk9, sp_out[2], irq, osc};
            end
            chk(seen, tbl[i]);
            cmd_n[i] <= 1'b1;
            repeat (24) @(posedge mclk_in);
         end
         seen = 32'h0;
         repeat (4) begin
            @(posedge mclk_in);
            seen |= {31'h0, |sh_out};
         end
         chk(seen, m);
      end
      close_out;
   end
endmodule
